// ---- core/arma_pkg.sv ----
// Register map constants and link request kinds for the accelerometer register block
package arma_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [6:0] ADDR_STATUS      = 7'h00;
   localparam logic [6:0] ADDR_X_MSB       = 7'h01;
   localparam logic [6:0] ADDR_X_LSB       = 7'h02;
   localparam logic [6:0] ADDR_Y_MSB       = 7'h03;
   localparam logic [6:0] ADDR_Y_LSB       = 7'h04;
   localparam logic [6:0] ADDR_Z_MSB       = 7'h05;
   localparam logic [6:0] ADDR_Z_LSB       = 7'h06;
   localparam logic [6:0] ADDR_BUF_SETUP   = 7'h09;
   localparam logic [6:0] ADDR_WRAP_TARGET = 7'h0D;
   localparam logic [6:0] ADDR_TAP_CONFIG  = 7'h21;
   localparam logic [6:0] ADDR_TAP_SOURCE  = 7'h22;
   localparam logic [6:0] ADDR_THS_X       = 7'h23;
   localparam logic [6:0] ADDR_THS_Y       = 7'h24;
   localparam logic [6:0] ADDR_THS_Z       = 7'h25;
   localparam logic [6:0] ADDR_TAP_TIME    = 7'h26;
   localparam logic [6:0] ADDR_TAP_LATENCY = 7'h27;
   localparam logic [6:0] ADDR_TAP_WINDOW  = 7'h28;
   localparam logic [6:0] ADDR_SLEEP_COUNT = 7'h29;
   localparam logic [6:0] ADDR_CTRL_ONE    = 7'h2A;
   localparam logic [6:0] ADDR_CTRL_TWO    = 7'h2B;
   localparam logic [6:0] ADDR_CTRL_THREE  = 7'h2C;
   localparam logic [6:0] ADDR_INT_ENABLE  = 7'h2D;
   localparam logic [6:0] ADDR_INT_ROUTE   = 7'h2E;
   localparam logic [6:0] ADDR_OFF_X       = 7'h2F;
   localparam logic [6:0] ADDR_OFF_Y       = 7'h30;
   localparam logic [6:0] ADDR_OFF_Z       = 7'h31;
   localparam logic [6:0] ADDR_RSVD_LO     = 7'h40;

   // ==========================================================
   // Sizes, reset values and field positions
   localparam int         CFG_COUNT          = 17;
   localparam logic [7:0] REG_RESET          = 8'h00;
   localparam logic [7:0] READ_ZERO          = 8'h00;
   localparam int         ACTIVE_BIT         = 0;
   localparam int         FAST_READ_BIT      = 1;
   localparam int         ODR_LSB            = 3;
   localparam int         ODR_MSB            = 5;
   localparam int         SOFT_RESET_BIT     = 6;
   localparam int         BUF_MODE_LSB       = 6;
   localparam int         BUF_MODE_MSB       = 7;
   localparam logic [1:0] BUF_MODE_OFF       = 2'h0;
   localparam logic [1:0] SYNC_RESET         = 2'h0;

   // ==========================================================
   // Link request kinds
   typedef enum logic [1:0] {
      ARMA_SET_POINTER,
      ARMA_WRITE,
      ARMA_READ,
      ARMA_STOP
   } arma_kind_t;

endpackage

// ---- core/arma_register_map.sv ----
// Register map access block: link handshake, pointer sequencing and register storage
//
// Overview of operation
// - Burst increments 0x21..0x30; 0x31 wraps to 0x0D
// - Only burst reads advance the register pointer
// - Stop condition clears the held pointer
// - Reserved 0x40..0x7F read zero, never written
// - All registers keep contents entering standby
// - Tap event source cleared entering active
// - Tap thresholds writable in standby and active
// - Threshold write resets its debounce counter
// - Other registers standby only, except 0x09 and the active and soft reset bits
// - Registers 0x21..0x31 reset to zero
// - Buffer off: address zero shows sample status
// - Buffer on: address zero shows buffer status
// - Fast read skips low data bytes
// - Normal burst gives six bytes X,Y,Z high/low
// - Status bits: overwrites high, ready flags low
// - Combined overwrite resets zero, sets on overwrite
// - Combined overwrite clears after all high bytes
// - Combined ready sets on sample, clears after reads
// - Low byte only right after its high byte
`timescale 1ns/1ps
`default_nettype none

module arma_register_map (
   // Core clock and reset
   input  wire logic                 CLK,
   input  wire logic                 RST_N,
   // Link side, on the link clock
   input  wire logic                 LINK_CLK,
   input  wire logic                 LINK_REQ,
   input  wire arma_pkg::arma_kind_t LINK_KIND,
   input  wire logic [7:0]           LINK_WDATA,
   output logic                      LINK_BUSY,
   output logic [7:0]                LINK_RDATA,
   output logic                      LINK_RVALID,
   // Sample source
   input  wire logic                 SAMPLE_VALID,
   input  wire logic [13:0]          SAMPLE_X,
   input  wire logic [13:0]          SAMPLE_Y,
   input  wire logic [13:0]          SAMPLE_Z,
   input  wire logic [2:0]           AXIS_ENABLE,
   input  wire logic [7:0]           BUFFER_STATUS,
   // Tap detector
   input  wire logic                 TAP_EVENT_LOAD,
   input  wire logic [7:0]           TAP_EVENT,
   // Control outputs
   output logic                      ACTIVE_MODE,
   output logic                      FAST_READ,
   output logic [2:0]                OUTPUT_DATA_RATE,
   output logic                      SOFT_RESET,
   output logic [1:0]                BUFFER_MODE,
   output logic [2:0]                TAP_DEBOUNCE_CLR
);

   // ==========================================================
   // Functions
   function automatic logic [4:0] cfg_index(input logic [6:0] a);
      cfg_index = 5'(a - arma_pkg::ADDR_TAP_CONFIG);
   endfunction

   function automatic logic [7:0] msb_byte(input logic [13:0] s);
      msb_byte = s[13:6];
   endfunction

   function automatic logic [7:0] lsb_byte(input logic [13:0] s);
      lsb_byte = {s[5:0], 2'h0};
   endfunction

   function automatic logic [6:0] next_address(input logic [6:0] a, input logic fast);
      case (a)
         arma_pkg::ADDR_X_MSB: begin
            next_address = fast ? arma_pkg::ADDR_Y_MSB : arma_pkg::ADDR_X_LSB;
         end
         arma_pkg::ADDR_Y_MSB: begin
            next_address = fast ? arma_pkg::ADDR_Z_MSB : arma_pkg::ADDR_Y_LSB;
         end
         arma_pkg::ADDR_Z_MSB: begin
            next_address = fast ? arma_pkg::ADDR_STATUS : arma_pkg::ADDR_Z_LSB;
         end
         arma_pkg::ADDR_OFF_Z: begin
            next_address = arma_pkg::ADDR_WRAP_TARGET;
         end
         default: begin
            next_address = 7'(a + 7'h01);
         end
      endcase
   endfunction

   // ==========================================================
   // Link domain: reset release and request capture
   logic [1:0]           link_rst_sync;
   logic                 link_rst_n;
   logic                 req_tgl;
   arma_pkg::arma_kind_t req_kind;
   logic [7:0]           req_data;
   logic [1:0]           ack_sync;
   logic                 ack_seen;
   logic                 ack_tgl;
   logic [7:0]           core_rdata;

   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         link_rst_sync <= arma_pkg::SYNC_RESET;
      end else begin
         link_rst_sync <= {link_rst_sync[0], 1'b1};
      end
   end

   assign link_rst_n = link_rst_sync[1];

   always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ack_sync <= arma_pkg::SYNC_RESET;
      end else begin
         ack_sync <= {ack_sync[0], ack_tgl};
      end
   end

   // Request fields held stable until the core answers
   always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         req_tgl     <= 1'b0;
         req_kind    <= arma_pkg::ARMA_SET_POINTER;
         req_data    <= arma_pkg::REG_RESET;
         ack_seen    <= 1'b0;
         LINK_BUSY   <= 1'b0;
         LINK_RDATA  <= arma_pkg::REG_RESET;
         LINK_RVALID <= 1'b0;
      end else begin
         LINK_RVALID <= 1'b0;
         if (LINK_BUSY && (ack_sync[1] != ack_seen)) begin
            ack_seen    <= ack_sync[1];
            LINK_BUSY   <= 1'b0;
            LINK_RDATA  <= core_rdata;
            LINK_RVALID <= (req_kind == arma_pkg::ARMA_READ);
         end else if (!LINK_BUSY && LINK_REQ) begin
            req_tgl   <= ~req_tgl;
            req_kind  <= LINK_KIND;
            req_data  <= LINK_WDATA;
            LINK_BUSY <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Core domain: request detection
   logic [1:0] req_sync;
   logic       req_seen;
   logic       req_fire;
   logic       do_addr;
   logic       do_write;
   logic       do_read;
   logic       do_stop;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         req_sync <= arma_pkg::SYNC_RESET;
         req_seen <= 1'b0;
         ack_tgl  <= 1'b0;
      end else begin
         req_sync <= {req_sync[0], req_tgl};
         req_seen <= req_sync[1];
         ack_tgl  <= ack_tgl ^ req_fire;
      end
   end

   assign req_fire = (req_sync[1] != req_seen);
   assign do_addr  = req_fire && (req_kind == arma_pkg::ARMA_SET_POINTER);
   assign do_write = req_fire && (req_kind == arma_pkg::ARMA_WRITE);
   assign do_read  = req_fire && (req_kind == arma_pkg::ARMA_READ);
   assign do_stop  = req_fire && (req_kind == arma_pkg::ARMA_STOP);

   // ==========================================================
   // Register storage
   logic [7:0] cfg [0:arma_pkg::CFG_COUNT-1];
   logic [7:0] buf_setup;
   logic [6:0] ptr;
   logic       in_cfg;
   logic [4:0] idx;
   logic       active;
   logic       fast;
   logic       buf_on;
   logic       going_active;

   assign in_cfg = (ptr >= arma_pkg::ADDR_TAP_CONFIG) && (ptr <= arma_pkg::ADDR_OFF_Z);
   assign idx    = cfg_index(ptr);
   assign active = cfg[cfg_index(arma_pkg::ADDR_CTRL_ONE)][arma_pkg::ACTIVE_BIT];
   assign fast   = cfg[cfg_index(arma_pkg::ADDR_CTRL_ONE)][arma_pkg::FAST_READ_BIT];
   assign buf_on = buf_setup[arma_pkg::BUF_MODE_MSB:arma_pkg::BUF_MODE_LSB]
                   != arma_pkg::BUF_MODE_OFF;
   assign going_active = do_write && (ptr == arma_pkg::ADDR_CTRL_ONE) && !active
                         && req_data[arma_pkg::ACTIVE_BIT];

   // Pointer moves only on reads, set by address byte, cleared by stop
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ptr <= arma_pkg::ADDR_STATUS;
      end else if (do_stop) begin
         ptr <= arma_pkg::ADDR_STATUS;
      end else if (do_addr) begin
         ptr <= req_data[6:0];
      end else if (do_read) begin
         ptr <= next_address(ptr, fast);
      end
   end

   // Upper map: reset to zero, kept across standby
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < arma_pkg::CFG_COUNT; i++) begin
            cfg[i] <= arma_pkg::REG_RESET;
         end
      end else begin
         if (TAP_EVENT_LOAD && active) begin
            cfg[cfg_index(arma_pkg::ADDR_TAP_SOURCE)] <= TAP_EVENT;
         end
         if (going_active) begin
            cfg[cfg_index(arma_pkg::ADDR_TAP_SOURCE)] <= arma_pkg::REG_RESET;
         end
         if (do_write && in_cfg) begin
            case (ptr)
               arma_pkg::ADDR_TAP_SOURCE: begin
               end
               arma_pkg::ADDR_THS_X, arma_pkg::ADDR_THS_Y, arma_pkg::ADDR_THS_Z: begin
                  cfg[idx] <= req_data;
               end
               arma_pkg::ADDR_CTRL_ONE: begin
                  if (!active) begin
                     cfg[idx] <= req_data;
                  end else begin
                     cfg[idx][arma_pkg::ACTIVE_BIT] <= req_data[arma_pkg::ACTIVE_BIT];
                  end
               end
               arma_pkg::ADDR_CTRL_TWO: begin
                  if (!active) begin
                     cfg[idx] <= req_data;
                  end else begin
                     cfg[idx][arma_pkg::SOFT_RESET_BIT] <=
                        req_data[arma_pkg::SOFT_RESET_BIT];
                  end
               end
               default: begin
                  if (!active) begin
                     cfg[idx] <= req_data;
                  end
               end
            endcase
         end
      end
   end

   // Buffer setup, writable in either mode
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         buf_setup <= arma_pkg::REG_RESET;
      end else if (do_write && (ptr == arma_pkg::ADDR_BUF_SETUP)) begin
         buf_setup <= req_data;
      end
   end

   // Threshold writes restart the matching debounce counter
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         TAP_DEBOUNCE_CLR <= 3'h0;
      end else begin
         TAP_DEBOUNCE_CLR <= {do_write && (ptr == arma_pkg::ADDR_THS_Z),
                              do_write && (ptr == arma_pkg::ADDR_THS_Y),
                              do_write && (ptr == arma_pkg::ADDR_THS_X)};
      end
   end

   // ==========================================================
   // Sample data and status flags
   logic [13:0] x_data;
   logic [13:0] y_data;
   logic [13:0] z_data;
   logic [2:0]  ready;
   logic [2:0]  over;
   logic        all_ready;
   logic        all_over;
   logic [2:0]  msb_read;
   logic [2:0]  ready_left;
   logic        pending;
   logic [7:0]  lsb_shadow;
   logic [6:0]  prev_read;

   assign msb_read = {do_read && (ptr == arma_pkg::ADDR_Z_MSB),
                      do_read && (ptr == arma_pkg::ADDR_Y_MSB),
                      do_read && (ptr == arma_pkg::ADDR_X_MSB)};
   assign ready_left = ready & ~msb_read;
   assign pending    = |(ready_left & AXIS_ENABLE);

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         x_data <= 14'h0000;
         y_data <= 14'h0000;
         z_data <= 14'h0000;
      end else if (SAMPLE_VALID) begin
         x_data <= SAMPLE_X;
         y_data <= SAMPLE_Y;
         z_data <= SAMPLE_Z;
      end
   end

   // A new sample beats a same-cycle high-byte read
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ready     <= 3'h0;
         over      <= 3'h0;
         all_ready <= 1'b0;
         all_over  <= 1'b0;
      end else begin
         ready <= ready_left | (SAMPLE_VALID ? AXIS_ENABLE : 3'h0);
         over  <= (over & ~msb_read) | (SAMPLE_VALID ? (AXIS_ENABLE & ready_left) : 3'h0);
         all_ready <= (SAMPLE_VALID && |AXIS_ENABLE) || (all_ready && pending);
         all_over  <= (SAMPLE_VALID && |(AXIS_ENABLE & ready_left))
                      || (all_over && pending);
      end
   end

   // Low byte captured with its high byte so both match
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         lsb_shadow <= arma_pkg::REG_RESET;
         prev_read  <= arma_pkg::ADDR_STATUS;
      end else if (req_fire) begin
         prev_read <= do_read ? ptr : arma_pkg::ADDR_STATUS;
         if (msb_read[0]) begin
            lsb_shadow <= lsb_byte(x_data);
         end else if (msb_read[1]) begin
            lsb_shadow <= lsb_byte(y_data);
         end else if (msb_read[2]) begin
            lsb_shadow <= lsb_byte(z_data);
         end
      end
   end

   // ==========================================================
   // Read data
   logic [7:0] rd;

   always_comb begin
      rd = arma_pkg::READ_ZERO;
      case (ptr)
         arma_pkg::ADDR_STATUS: begin
            if (buf_on) begin
               rd = BUFFER_STATUS;
            end else begin
               rd = {all_over, over[2], over[1], over[0],
                     all_ready, ready[2], ready[1], ready[0]};
            end
         end
         arma_pkg::ADDR_X_MSB: begin
            rd = msb_byte(x_data);
         end
         arma_pkg::ADDR_Y_MSB: begin
            rd = msb_byte(y_data);
         end
         arma_pkg::ADDR_Z_MSB: begin
            rd = msb_byte(z_data);
         end
         arma_pkg::ADDR_X_LSB: begin
            rd = (prev_read == arma_pkg::ADDR_X_MSB) ? lsb_shadow : arma_pkg::READ_ZERO;
         end
         arma_pkg::ADDR_Y_LSB: begin
            rd = (prev_read == arma_pkg::ADDR_Y_MSB) ? lsb_shadow : arma_pkg::READ_ZERO;
         end
         arma_pkg::ADDR_Z_LSB: begin
            rd = (prev_read == arma_pkg::ADDR_Z_MSB) ? lsb_shadow : arma_pkg::READ_ZERO;
         end
         arma_pkg::ADDR_BUF_SETUP: begin
            rd = buf_setup;
         end
         default: begin
            rd = in_cfg ? cfg[idx] : arma_pkg::READ_ZERO;
         end
      endcase
   end

   // Held until the next read; link copies it after the answer toggle
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         core_rdata <= arma_pkg::REG_RESET;
      end else if (do_read) begin
         core_rdata <= rd;
      end
   end

   // ==========================================================
   // Control outputs
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ACTIVE_MODE      <= 1'b0;
         FAST_READ        <= 1'b0;
         OUTPUT_DATA_RATE <= 3'h0;
         SOFT_RESET       <= 1'b0;
         BUFFER_MODE      <= 2'h0;
      end else begin
         ACTIVE_MODE      <= active;
         FAST_READ        <= fast;
         OUTPUT_DATA_RATE <= cfg[cfg_index(arma_pkg::ADDR_CTRL_ONE)]
                             [arma_pkg::ODR_MSB:arma_pkg::ODR_LSB];
         SOFT_RESET       <= cfg[cfg_index(arma_pkg::ADDR_CTRL_TWO)][arma_pkg::SOFT_RESET_BIT];
         BUFFER_MODE      <= buf_setup[arma_pkg::BUF_MODE_MSB:arma_pkg::BUF_MODE_LSB];
      end
   end

endmodule

`default_nettype wire

// ---- test/arma_register_map_props.sv ----
// Port checks bound into the register block
`timescale 1ns/1ps
`default_nettype none

module arma_register_map_props (
   // Clocks and reset
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic       LINK_CLK,
   // Link side
   input wire logic       LINK_REQ,
   input wire logic       LINK_BUSY,
   input wire logic [7:0] LINK_RDATA,
   input wire logic       LINK_RVALID,
   // Control outputs
   input wire logic       ACTIVE_MODE,
   input wire logic       FAST_READ,
   input wire logic [2:0] OUTPUT_DATA_RATE,
   input wire logic [2:0] TAP_DEBOUNCE_CLR
);
   // ==========================================================
   // Link handshake
   busy_rise_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      LINK_REQ && !LINK_BUSY |=> LINK_BUSY) else $error("busy did not rise");
   busy_bound_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      $rose(LINK_BUSY) |-> LINK_BUSY[*3] ##[1:5] !LINK_BUSY)
      else $error("answer outside allowed window");
   rvalid_pulse_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      LINK_RVALID |=> !LINK_RVALID) else $error("read answer too long");
   rvalid_idle_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      LINK_RVALID |-> !LINK_BUSY) else $error("answer while busy");
   rdata_hold_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
      !LINK_RVALID |-> $stable(LINK_RDATA)) else $error("read data moved");
   // ==========================================================
   // Mode and control
   odr_standby_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !$stable(OUTPUT_DATA_RATE) |-> !$past(ACTIVE_MODE)) else $error("rate changed when active");
   fast_standby_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !$stable(FAST_READ) |-> !$past(ACTIVE_MODE)) else $error("fast read changed when active");
   standby_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
      $fell(ACTIVE_MODE) |-> $stable(OUTPUT_DATA_RATE) && $stable(FAST_READ))
      else $error("control lost entering standby");
   clr_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N)
      (|TAP_DEBOUNCE_CLR) |=> TAP_DEBOUNCE_CLR == 3'h0) else $error("clear not a pulse");
   clr_onehot_a: assert property (@(posedge CLK) disable iff (!RST_N)
      $onehot0(TAP_DEBOUNCE_CLR)) else $error("several clears at once");
   // ==========================================================
   // Coverage
   cover property (@(posedge LINK_CLK) disable iff (!RST_N) LINK_RVALID);
   cover property (@(posedge CLK) disable iff (!RST_N) $rose(ACTIVE_MODE));
   cover property (@(posedge CLK) disable iff (!RST_N) (|TAP_DEBOUNCE_CLR));
endmodule

bind arma_register_map arma_register_map_props props_i (
   .CLK(CLK), .RST_N(RST_N), .LINK_CLK(LINK_CLK), .LINK_REQ(LINK_REQ),
   .LINK_BUSY(LINK_BUSY), .LINK_RDATA(LINK_RDATA), .LINK_RVALID(LINK_RVALID),
   .ACTIVE_MODE(ACTIVE_MODE), .FAST_READ(FAST_READ),
   .OUTPUT_DATA_RATE(OUTPUT_DATA_RATE), .TAP_DEBOUNCE_CLR(TAP_DEBOUNCE_CLR));

`default_nettype wire

// ---- test/arma_host_model.sv ----
// Host link master model issuing byte-level requests
`timescale 1ns/1ps
`default_nettype none

module arma_host_model (
   // Link
   input  wire logic                 LINK_CLK,
   input  wire logic                 LINK_BUSY,
   input  wire logic [7:0]           LINK_RDATA,
   output var  logic                 LINK_REQ,
   output var  arma_pkg::arma_kind_t LINK_KIND,
   output var  logic [7:0]           LINK_WDATA
);
   initial begin
      LINK_REQ   = 1'b0;
      LINK_KIND  = arma_pkg::ARMA_STOP;
      LINK_WDATA = 8'h00;
   end

   // One request
   task automatic xfer(input arma_pkg::arma_kind_t kind, input logic [7:0] wd,
                       output logic [7:0] rd);
      @(posedge LINK_CLK);
      LINK_REQ   <= 1'b1;
      LINK_KIND  <= kind;
      LINK_WDATA <= wd;
      @(posedge LINK_CLK);
      LINK_REQ   <= 1'b0;
      LINK_WDATA <= ~wd;
      repeat (12) begin
         @(posedge LINK_CLK);
         #1;
         if (!LINK_BUSY) break;
      end
      rd = LINK_RDATA;
   endtask
endmodule

`default_nettype wire

// ---- test/accel_register_map_access_tb.sv ----
// Self-checking bench for the register map block
`timescale 1ns/1ps
`default_nettype none

module accel_register_map_access_tb;
   logic                 CLK = 1'b0;
   logic                 RST_N = 1'b0;
   logic                 LINK_CLK = 1'b0;
   logic                 LINK_REQ;
   arma_pkg::arma_kind_t LINK_KIND;
   logic [7:0]           LINK_WDATA;
   logic                 LINK_BUSY;
   logic [7:0]           LINK_RDATA;
   logic                 LINK_RVALID;
   logic                 SAMPLE_VALID = 1'b0;
   logic [13:0]          SAMPLE_X;
   logic [13:0]          SAMPLE_Y;
   logic [13:0]          SAMPLE_Z;
   logic [2:0]           AXIS_ENABLE;
   logic [7:0]           BUFFER_STATUS;
   logic                 TAP_EVENT_LOAD = 1'b0;
   logic [7:0]           TAP_EVENT;
   logic                 ACTIVE_MODE;
   logic                 FAST_READ;
   logic [2:0]           OUTPUT_DATA_RATE;
   logic                 SOFT_RESET;
   logic [1:0]           BUFFER_MODE;
   logic [2:0]           TAP_DEBOUNCE_CLR;
   logic [2:0]           clr_seen = 3'h0;
   logic [7:0]           rdat;
   logic [7:0]           eq[$];
   int                   n_mismatch = 0;
   int                   total_checks = 0;
   localparam logic [13:0] x1 = 14'h2A5C, y1 = 14'h1337, z1 = 14'h0F81;
   localparam logic [13:0] x2 = 14'h3FC3, y2 = 14'h0246, z2 = 14'h1A5A;
   localparam logic [13:0] x3 = 14'h05A1, y3 = 14'h2C3E, z3 = 14'h3107;

   always #2.5 CLK = ~CLK;
   initial begin
      #1.7;
      forever #3 LINK_CLK = ~LINK_CLK;
   end
   always @(posedge CLK) clr_seen <= clr_seen | TAP_DEBOUNCE_CLR;

   arma_register_map dut (
      .CLK(CLK), .RST_N(RST_N), .LINK_CLK(LINK_CLK), .LINK_REQ(LINK_REQ),
      .LINK_KIND(LINK_KIND), .LINK_WDATA(LINK_WDATA), .LINK_BUSY(LINK_BUSY),
      .LINK_RDATA(LINK_RDATA), .LINK_RVALID(LINK_RVALID), .SAMPLE_VALID(SAMPLE_VALID),
      .SAMPLE_X(SAMPLE_X), .SAMPLE_Y(SAMPLE_Y), .SAMPLE_Z(SAMPLE_Z),
      .AXIS_ENABLE(AXIS_ENABLE), .BUFFER_STATUS(BUFFER_STATUS),
      .TAP_EVENT_LOAD(TAP_EVENT_LOAD), .TAP_EVENT(TAP_EVENT), .ACTIVE_MODE(ACTIVE_MODE),
      .FAST_READ(FAST_READ), .OUTPUT_DATA_RATE(OUTPUT_DATA_RATE), .SOFT_RESET(SOFT_RESET),
      .BUFFER_MODE(BUFFER_MODE), .TAP_DEBOUNCE_CLR(TAP_DEBOUNCE_CLR));

   arma_host_model host (
      .LINK_CLK(LINK_CLK), .LINK_BUSY(LINK_BUSY), .LINK_RDATA(LINK_RDATA),
      .LINK_REQ(LINK_REQ), .LINK_KIND(LINK_KIND), .LINK_WDATA(LINK_WDATA));

   // ==========================================================
   // Shared helpers
   function automatic logic [7:0] hi(input logic [13:0] s);
      return s[13:6];
   endfunction
   function automatic logic [7:0] lo(input logic [13:0] s);
      return {s[5:0], 2'b00};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] exp);
      host.xfer(arma_pkg::ARMA_READ, 8'h00, rdat);
      chk(rdat, exp);
      chk({7'h00, LINK_RVALID}, 8'h01);
   endtask
   task automatic setp(input logic [6:0] a);
      host.xfer(arma_pkg::ARMA_SET_POINTER, {1'b0, a}, rdat);
   endtask
   task automatic stop;
      host.xfer(arma_pkg::ARMA_STOP, 8'h00, rdat);
   endtask
   // Reads queued bytes
   task automatic burst(input logic [6:0] a);
      setp(a);
      foreach (eq[i]) rd(eq[i]);
      stop();
      eq.delete();
   endtask
   // Write, read back
   task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] exp);
      setp(a);
      host.xfer(arma_pkg::ARMA_WRITE, d, rdat);
      rd(exp);
      stop();
   endtask
   task automatic push(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z,
                       input logic [2:0] en = 3'h7);
      @(posedge CLK);
      SAMPLE_VALID <= 1'b1;
      SAMPLE_X     <= x;
      SAMPLE_Y     <= y;
      SAMPLE_Z     <= z;
      AXIS_ENABLE  <= en;
      @(posedge CLK);
      SAMPLE_VALID <= 1'b0;
      @(posedge CLK);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs;
      for (int a = 8'h21; a <= 8'h31; a++) eq.push_back(8'h00);
      burst(7'h21);
      for (int a = 8'h21; a <= 8'h31; a++)
         wr(a[6:0], a[7:0] + 8'h40, (a == 8'h22) ? 8'h00 : a[7:0] + 8'h40);
      for (int a = 8'h21; a <= 8'h31; a++) eq.push_back((a == 8'h22) ? 8'h00 : a[7:0] + 8'h40);
      for (int i = 0; i < 20; i++) eq.push_back(8'h00);
      eq.push_back(8'h61);
      burst(7'h21);
      chk({5'h00, FAST_READ, SOFT_RESET, ACTIVE_MODE}, 8'h06);
      chk({5'h00, OUTPUT_DATA_RATE}, 8'h05);
      eq.push_back(8'h00);
      burst(7'h45);
   endtask

   task automatic t_active;
      clr_seen = 3'h0;
      wr(7'h2A, 8'h6B, 8'h6B);
      chk({7'h00, ACTIVE_MODE}, 8'h01);
      wr(7'h26, 8'h11, 8'h66);
      wr(7'h2A, 8'h81, 8'h6B);
      wr(7'h2B, 8'h00, 8'h2B);
      for (int a = 8'h23; a <= 8'h25; a++) wr(a[6:0], 8'h9D, 8'h9D);
      chk({5'h00, clr_seen}, 8'h07);
      @(posedge CLK);
      TAP_EVENT      <= 8'h5C;
      TAP_EVENT_LOAD <= 1'b1;
      @(posedge CLK);
      TAP_EVENT_LOAD <= 1'b0;
      wr(7'h2A, 8'h00, 8'h6A);
      eq.push_back(8'h5C);
      eq.push_back(8'h9D);
      burst(7'h22);
      wr(7'h2A, 8'h6B, 8'h6B);
      eq.push_back(8'h00);
      burst(7'h22);
      wr(7'h2A, 8'h00, 8'h6A);
   endtask

   task automatic t_samples;
      wr(7'h2A, 8'h28, 8'h28);
      push(x1, y1, z1);
      eq.push_back(8'h0F);
      burst(7'h00);
      push(x2, y2, z2);
      setp(7'h00);
      rd(8'hFF);
      rd(hi(x2));
      push(x3, y3, z3);
      rd(lo(x2));
      rd(hi(y3));
      rd(lo(y3));
      rd(hi(z3));
      rd(lo(z3));
      stop();
      eq.push_back(8'h89);
      burst(7'h00);
      eq.push_back(hi(x3));
      eq.push_back(lo(x3));
      eq.push_back(hi(y3));
      burst(7'h01);
      eq.push_back(8'h00);
      burst(7'h00);
      eq.push_back(8'h00);
      burst(7'h04);
      push(x2, y2, z2, 3'h3);
      eq.push_back(8'h0B);
      burst(7'h00);
      wr(7'h2A, 8'h2A, 8'h2A);
      push(x1, y1, z1);
      eq = '{hi(x1), hi(y1), hi(z1), 8'h00};
      burst(7'h01);
      wr(7'h2A, 8'h28, 8'h28);
   endtask

   task automatic t_buffer;
      for (int m = 1; m <= 3; m++) begin
         wr(7'h09, {m[1:0], 6'h00}, {m[1:0], 6'h00});
         chk({6'h00, BUFFER_MODE}, {6'h00, m[1:0]});
         @(posedge CLK) BUFFER_STATUS <= 8'hA4 + m[7:0];
         eq.push_back(8'hA4 + m[7:0]);
         burst(7'h00);
      end
      push(x2, y2, z2);
      eq.push_back(hi(x2));
      burst(7'h01);
      wr(7'h09, 8'h00, 8'h00);
      setp(7'h25);
      stop();
      rd(8'h0E);
      stop();
   endtask

   task automatic stop_test;
      if (n_mismatch == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (4) @(posedge LINK_CLK);
      t_regs();
      t_active();
      t_samples();
      t_buffer();
      stop_test();
   end

   initial begin
      #100000;
      n_mismatch++;
      stop_test();
   end
endmodule

`default_nettype wire
